// [tel_pkg.sv]
package tel_pkg;

  // ----------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] TEL_OFF_STATUS = 8'h00;
  localparam logic [7:0] TEL_OFF_EXT = 8'h04;
  localparam logic [7:0] TEL_OFF_FAULT_ADDR = 8'h08;
  localparam logic [7:0] TEL_OFF_DEBUG_ADDR = 8'h0C;
  localparam logic [7:0] TEL_OFF_FP_STATUS = 8'h10;
  localparam logic [7:0] TEL_OFF_LOCK = 8'h14;

  // ----------------------------------------
  // Processor status register fields
  // ----------------------------------------
  localparam int TEL_PS_APP = 0;
  localparam int TEL_PS_PREV_APP = 1;
  localparam int TEL_PS_IRQ = 2;
  localparam int TEL_PS_PREV_IRQ = 3;
  localparam int TEL_PS_IFAULT = 4;
  localparam int TEL_PS_EXTIRQ = 5;
  localparam int TEL_PS_FETCH = 6;
  localparam int TEL_PS_OPND = 7;
  localparam int TEL_PS_FPF = 8;
  localparam int TEL_PS_DUAL = 9;
  localparam int TEL_PS_SWAP = 10;
  localparam logic [10:0] TEL_PS_RESET = 11'h004;
  localparam logic [10:0] TEL_PS_W1C = 11'h1F0;

  // ----------------------------------------
  // Extended status register fields
  // ----------------------------------------
  localparam int TEL_EX_OVFL = 0;
  localparam int TEL_EX_LOCKTO = 1;
  localparam int TEL_EX_FPUSE = 2;
  localparam int TEL_EX_UNSAVED = 3;
  localparam int TEL_EX_BUSERR = 4;
  localparam int TEL_EX_PARERR = 5;
  localparam logic [5:0] TEL_EX_RESET = 6'h00;
  localparam logic [5:0] TEL_EX_W1C = 6'h3A;

  // ----------------------------------------
  // Trap vector, pair step and lock limit
  // ----------------------------------------
  localparam logic [31:0] TEL_TRAP_VECTOR = 32'h0FFFFF00;
  localparam logic [31:0] TEL_PAIR_STEP = 32'h00000004;
  localparam int TEL_LOCK_LIMIT = 30;
  localparam logic [4:0] TEL_LOCK_LIMIT_W = 5'h1E;

endpackage

// [tel_trap_entry.sv]
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Contract
// RULE_01: Save mode and irq enable, then clear both
// RULE_02: Record dual mode at trap entry
// RULE_03: Record pending mode switch at trap entry
// RULE_04: Set all present cause flags together
// RULE_05: Fault address is trapped or FP half
// RULE_06: Lone operand fault completes FP half first
// RULE_07: Redirect fetch to vector in single mode
// RULE_08: Abort instruction, restartable except bus errors; code also makes parity error traps non-restartable
// RULE_09: Instruction fault flag for all four causes
// RULE_10: Trap instruction skips FP companion
// RULE_11: Overflow check traps only on overflow flag
// RULE_12: Overflow check completes FP companion first
// RULE_13: Pipeline use traps while use trap set
// RULE_14: Bus lock from first access after lock
// RULE_15: Lock exceeding 30 instructions faults, sets timeout
// RULE_16: Unaccessed page: brief lock, unlock, relock; code keeps the lock off for that access and asserts it from the next cycle
// RULE_17: Pipeline use trap sets fault and unsaved
// RULE_18: Pipelined FP or pipe load sets unsaved
// RULE_19: Pending FP exception traps at next FP op
// RULE_20: Parity error with check pin raises fault
// RULE_21: Bus fail pin raises bus error trap
// RULE_22: Operand fault on debug match, translation, alignment
// RULE_23: All entry updates in the redirect cycle
module tel_trap_entry #(
  parameter int ADDR_W = 32,
  parameter int LOCK_LIMIT = tel_pkg::TEL_LOCK_LIMIT
) (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Retiring instruction from the core
  input wire logic i_retire,
  input wire logic [ADDR_W-1:0] i_instr_addr,
  input wire logic i_dual_mode,
  input wire logic i_next_dual,
  input wire logic i_is_trap_op,
  input wire logic i_is_ovfl_check,
  input wire logic i_uses_pipe,
  input wire logic i_is_pipelined_fp,
  input wire logic i_is_pipe_fp_load,
  input wire logic i_is_fp_op,
  input wire logic i_is_fp_to_gp,
  input wire logic i_is_lock,
  input wire logic i_is_unlock,
  input wire logic i_is_mem,
  input wire logic i_page_accessed,
  input wire logic [ADDR_W-1:0] i_opnd_addr,
  input wire logic i_xlate_fail,
  input wire logic i_misaligned,
  input wire logic i_fetch_fault,
  input wire logic i_int_ovfl,
  input wire logic i_bus_read,
  input wire logic i_parity_bad,
  // External pins
  input wire logic i_ext_irq_pin,
  input wire logic i_bus_fail_pin,
  input wire logic i_parity_check_pin,
  // Trap entry outputs
  output logic o_trap,
  output logic [ADDR_W-1:0] o_fetch_addr,
  output logic o_handler_single,
  output logic o_abort,
  output logic o_restartable,
  output logic o_fp_half_commit,
  output logic o_bus_lock
);

  initial
  begin
    if (ADDR_W != 32 || LOCK_LIMIT < 1 || LOCK_LIMIT > 31)
      $error("tel_trap_entry: unsupported parameters");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {LK_IDLE, LK_ARMED, LK_HELD, LK_CLOSING} tel_lock_t;

  typedef struct packed {
    logic [2:0] irq_s;
    logic [2:0] bus_s;
    logic [2:0] par_s;
    logic [10:0] psr;
    logic [5:0] epsr;
    logic [ADDR_W-1:0] fault_addr_reg;
    logic [ADDR_W-1:0] dbg_addr;
    logic [5:0] fp_status_reg;
    logic fp_trap_en;
    tel_lock_t lk;
    logic [4:0] lk_cnt;
    logic trap;
    logic [ADDR_W-1:0] fetch_addr;
    logic abort;
    logic restartable;
    logic fp_commit;
    logic bus_lock;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tel_state_t;

  tel_state_t r;
  tel_state_t next_r;

  logic wr_psr, wr_ex, wr_dbg, wr_fps, wr_lk, rd_hit;
  logic dbg_hit, opnd_fault, ovfl_trap, pipe_trap, lock_to, par_trap;
  logic bus_trap, irq_trap, fp_trap, any_trap, lone_opnd;

  // ----------------------------------------
  // Trap condition decode
  // ----------------------------------------
  always_comb
  begin
    wr_psr = 1'b0;
    wr_ex = 1'b0;
    wr_dbg = 1'b0;
    wr_fps = 1'b0;
    wr_lk = 1'b0;
    rd_hit = 1'b1;
    if (i_paddr == tel_pkg::TEL_OFF_STATUS) wr_psr = 1'b1;
    else if (i_paddr == tel_pkg::TEL_OFF_EXT) wr_ex = 1'b1;
    else if (i_paddr == tel_pkg::TEL_OFF_FAULT_ADDR) rd_hit = 1'b1;
    else if (i_paddr == tel_pkg::TEL_OFF_DEBUG_ADDR) wr_dbg = 1'b1;
    else if (i_paddr == tel_pkg::TEL_OFF_FP_STATUS) wr_fps = 1'b1;
    else if (i_paddr == tel_pkg::TEL_OFF_LOCK) wr_lk = 1'b1;
    else rd_hit = 1'b0;
    dbg_hit = i_retire && i_is_mem && (i_opnd_addr == r.dbg_addr);
    opnd_fault = dbg_hit || (i_retire && i_is_mem && (i_xlate_fail || i_misaligned)); // RULE_22
    ovfl_trap = i_retire && i_is_ovfl_check && r.epsr[tel_pkg::TEL_EX_OVFL]; // RULE_11
    pipe_trap = i_retire && i_uses_pipe && r.fp_trap_en; // RULE_13
    // A closing access later than the limit is itself a violation
    lock_to = i_retire && (r.lk != LK_IDLE) && (r.lk_cnt >= 5'(LOCK_LIMIT)); // RULE_15
    fp_trap = i_retire && i_is_fp_op && r.fp_trap_en && (r.fp_status_reg != 6'h00); // RULE_19
    par_trap = i_bus_read && i_parity_bad && r.par_s[2]
      && !r.epsr[tel_pkg::TEL_EX_PARERR]; // RULE_20
    bus_trap = r.bus_s[2]; // RULE_21
    irq_trap = r.irq_s[2] && r.psr[tel_pkg::TEL_PS_IRQ];
    any_trap = (i_retire && (i_is_trap_op || i_fetch_fault)) || ovfl_trap || pipe_trap
      || lock_to || opnd_fault || fp_trap || par_trap || bus_trap || irq_trap;
    lone_opnd = opnd_fault && !(i_is_trap_op || ovfl_trap || pipe_trap || lock_to
      || fp_trap || par_trap || bus_trap || irq_trap || i_fetch_fault);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.irq_s = {r.irq_s[1:0], i_ext_irq_pin};
    next_r.bus_s = {r.bus_s[1:0], i_bus_fail_pin};
    next_r.par_s = {r.par_s[1:0], i_parity_check_pin};
    next_r.trap = 1'b0;
    next_r.abort = 1'b0;
    next_r.fp_commit = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // APB access, answered in the access phase
    if (i_psel && !i_penable)
    begin
      next_r.pready = 1'b1;
      next_r.pslverr = !rd_hit;
      next_r.prdata = 32'h00000000;
      if (wr_psr) next_r.prdata = {21'h000000, r.psr};
      else if (wr_ex) next_r.prdata = {26'h0000000, r.epsr};
      else if (rd_hit && !wr_dbg && !wr_fps && !wr_lk) next_r.prdata = r.fault_addr_reg;
      else if (wr_dbg) next_r.prdata = r.dbg_addr;
      else if (wr_fps) next_r.prdata = {25'h0000000, r.fp_trap_en, r.fp_status_reg};
      else if (wr_lk) next_r.prdata = {25'h0000000, r.bus_lock, r.lk_cnt, 1'b0};
    end
    if (i_psel && i_penable && r.pready && i_pwrite)
    begin
      if (wr_psr) next_r.psr = (i_pwdata[10:0] & ~tel_pkg::TEL_PS_W1C)
        | (r.psr & tel_pkg::TEL_PS_W1C & ~i_pwdata[10:0]);
      else if (wr_ex) next_r.epsr = (i_pwdata[5:0] & ~tel_pkg::TEL_EX_W1C)
        | (r.epsr & tel_pkg::TEL_EX_W1C & ~i_pwdata[5:0]);
      else if (wr_dbg) next_r.dbg_addr = i_pwdata;
      else if (wr_fps)
      begin
        next_r.fp_status_reg = i_pwdata[5:0];
        next_r.fp_trap_en = i_pwdata[6];
      end
    end
    // Pipeline state tracking
    if (i_retire && (i_is_pipelined_fp || i_is_pipe_fp_load))
      next_r.epsr[tel_pkg::TEL_EX_UNSAVED] = 1'b1; // RULE_18
    next_r.epsr[tel_pkg::TEL_EX_OVFL] = next_r.epsr[tel_pkg::TEL_EX_OVFL] | i_int_ovfl;
    // Lock sequence
    case (r.lk)
      LK_IDLE:
      begin
        next_r.bus_lock = 1'b0;
        if (i_retire && i_is_lock)
        begin
          next_r.lk = LK_ARMED;
          next_r.lk_cnt = 5'h00;
        end
      end
      LK_ARMED:
      begin
        if (i_retire && i_is_mem)
        begin
          next_r.lk = LK_HELD;
          next_r.bus_lock = i_page_accessed; // RULE_16
        end
      end
      LK_HELD:
      begin
        next_r.bus_lock = 1'b1; // RULE_14
        if (i_retire && i_is_unlock) next_r.lk = LK_CLOSING;
      end
      LK_CLOSING:
      begin
        if (i_retire && i_is_mem)
        begin
          next_r.lk = LK_IDLE;
          next_r.bus_lock = 1'b0; // RULE_14
        end
      end
      default: next_r.lk = LK_IDLE;
    endcase
    if (i_retire && r.lk != LK_IDLE && r.lk_cnt != 5'h1F)
      next_r.lk_cnt = r.lk_cnt + 5'h01; // RULE_15
    // Trap entry, all updates in the redirect cycle
    if (any_trap)
    begin
      next_r.trap = 1'b1; // RULE_23
      next_r.fetch_addr = tel_pkg::TEL_TRAP_VECTOR; // RULE_07
      next_r.abort = 1'b1; // RULE_08
      next_r.restartable = !(bus_trap || par_trap); // RULE_08
      next_r.fp_commit = i_dual_mode && !i_is_trap_op
        && (ovfl_trap || (lone_opnd && !i_is_fp_to_gp)); // RULE_06 RULE_10 RULE_12
      next_r.psr[tel_pkg::TEL_PS_PREV_APP] = r.psr[tel_pkg::TEL_PS_APP]; // RULE_01
      next_r.psr[tel_pkg::TEL_PS_PREV_IRQ] = r.psr[tel_pkg::TEL_PS_IRQ]; // RULE_01
      next_r.psr[tel_pkg::TEL_PS_APP] = 1'b0; // RULE_01
      next_r.psr[tel_pkg::TEL_PS_IRQ] = 1'b0; // RULE_01
      next_r.psr[tel_pkg::TEL_PS_DUAL] = i_dual_mode; // RULE_02
      next_r.psr[tel_pkg::TEL_PS_SWAP] = i_dual_mode != i_next_dual; // RULE_03
      // Every present cause sets its flag at once
      if ((i_retire && i_is_trap_op) || ovfl_trap || pipe_trap || lock_to)
        next_r.psr[tel_pkg::TEL_PS_IFAULT] = 1'b1; // RULE_04 RULE_09
      if (par_trap || bus_trap || irq_trap) next_r.psr[tel_pkg::TEL_PS_EXTIRQ] = 1'b1;
      if (i_retire && i_fetch_fault) next_r.psr[tel_pkg::TEL_PS_FETCH] = 1'b1;
      if (opnd_fault) next_r.psr[tel_pkg::TEL_PS_OPND] = 1'b1; // RULE_22
      if (fp_trap) next_r.psr[tel_pkg::TEL_PS_FPF] = 1'b1; // RULE_19
      if (lock_to)
      begin
        next_r.epsr[tel_pkg::TEL_EX_LOCKTO] = 1'b1; // RULE_15
        next_r.lk = LK_IDLE;
        next_r.bus_lock = 1'b0;
      end
      if (pipe_trap)
      begin
        next_r.epsr[tel_pkg::TEL_EX_FPUSE] = 1'b1;
        next_r.epsr[tel_pkg::TEL_EX_UNSAVED] = 1'b1; // RULE_17
      end
      if (bus_trap) next_r.epsr[tel_pkg::TEL_EX_BUSERR] = 1'b1; // RULE_21
      if (par_trap) next_r.epsr[tel_pkg::TEL_EX_PARERR] = 1'b1; // RULE_20
      next_r.fault_addr_reg = i_instr_addr; // RULE_05
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.psr <= tel_pkg::TEL_PS_RESET;
      r.epsr <= tel_pkg::TEL_EX_RESET;
      r.lk <= LK_IDLE;
      r.fetch_addr <= tel_pkg::TEL_TRAP_VECTOR;
    end
    else if (i_ce)
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_prdata = r.prdata;
  assign o_pready = r.pready;
  assign o_pslverr = r.pslverr;
  assign o_trap = r.trap;
  assign o_fetch_addr = r.fetch_addr;
  assign o_handler_single = r.trap; // RULE_07
  assign o_abort = r.abort;
  assign o_restartable = r.restartable;
  assign o_fp_half_commit = r.fp_commit;
  assign o_bus_lock = r.bus_lock;

endmodule

// [tel_trap_entry_sva.sv]
`timescale 1ns/1ps
module tel_trap_entry_sva (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_ce,
  input wire logic i_retire,
  input wire logic i_is_trap_op,
  input wire logic i_is_ovfl_check,
  input wire logic i_int_ovfl,
  input wire logic i_is_mem,
  input wire logic i_bus_fail_pin,
  input wire logic o_trap,
  input wire logic [31:0] o_fetch_addr,
  input wire logic o_handler_single,
  input wire logic o_abort,
  input wire logic o_bus_lock
);
  // --------------
  // Trap entry and bus lock
  // --------------
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  a_trap_abort: assert property (o_trap |-> o_abort)
    else $error("trap without abort");
  a_handler_mode: assert property (o_trap |-> o_handler_single)
    else $error("handler not single");
  a_trap_vector: assert property (o_trap |-> o_fetch_addr == tel_pkg::TEL_TRAP_VECTOR)
    else $error("wrong vector");
  a_trap_op: assert property (i_ce && i_retire && i_is_trap_op |=> o_trap)
    else $error("trap op ignored");
  a_ovfl_trap: assert property (i_ce && $past(i_ce) && i_retire && i_is_ovfl_check
    && $past(i_int_ovfl) |=> o_trap) else $error("overflow check ignored");
  a_bus_fail: assert property ($rose(i_bus_fail_pin) |-> ##[1:6] o_trap)
    else $error("bus fail not trapped");
  a_lock_rise: assert property ($rose(o_bus_lock) |-> $past(i_retire) && $past(i_is_mem) ||
    $past(i_retire, 2) && $past(i_is_mem, 2)) else $error("lock without access");
  a_lock_fall: assert property ($fell(o_bus_lock) |-> o_trap || $past(i_retire) && $past(i_is_mem))
    else $error("unlock without access");
  c_trap: cover property (o_trap);
  c_lock: cover property ($rose(o_bus_lock));
  c_unlock: cover property ($fell(o_bus_lock));
endmodule
bind tel_trap_entry tel_trap_entry_sva u_sva (.i_ref_clk, .i_rst, .i_ce, .i_retire,
  .i_is_trap_op, .i_is_ovfl_check, .i_int_ovfl, .i_is_mem, .i_bus_fail_pin, .o_trap,
  .o_fetch_addr, .o_handler_single, .o_abort, .o_bus_lock);

// [tel_pin_source.sv]
`timescale 1ns/1ps
module tel_pin_source (
  // Clock
  input wire logic i_ref_clk,
  // Bench request
  input wire logic i_fire_bus_fail_pin,
  // Pins toward the block
  output logic o_ext_irq_pin,
  output logic o_bus_fail_pin,
  output logic o_parity_check_pin
);
  // Pins change only after a clock edge; idle sources stay low
  always_ff @(posedge i_ref_clk)
  begin
    o_ext_irq_pin <= 1'h0;
    o_parity_check_pin <= 1'h0;
    o_bus_fail_pin <= i_fire_bus_fail_pin;
  end
endmodule

// [tel_trap_entry_tb_top.sv]
`timescale 1ns/1ps
module tel_trap_entry_tb_top;
  // --------------
  // Signals
  // --------------
  localparam logic [7:0] PS = tel_pkg::TEL_OFF_STATUS;
  localparam logic [7:0] EX = tel_pkg::TEL_OFF_EXT;
  logic i_ref_clk, i_rst, i_ce, i_psel, i_penable, i_pwrite, i_retire, i_int_ovfl;
  logic i_bus_read, i_parity_bad, fire_bus_fail_pin, i_ext_irq_pin, i_bus_fail_pin, perr;
  logic i_parity_check_pin, o_pready, o_pslverr, o_trap, o_handler_single, o_abort;
  logic o_restartable, o_fp_half_commit, o_bus_lock, i_dual_mode, i_next_dual;
  logic i_is_trap_op, i_is_ovfl_check, i_uses_pipe, i_is_pipelined_fp, i_is_pipe_fp_load;
  logic i_is_fp_op, i_is_fp_to_gp, i_is_lock, i_is_unlock, i_is_mem, i_page_accessed;
  logic i_xlate_fail, i_misaligned, i_fetch_fault;
  logic [7:0] i_paddr;
  logic [15:0] cls;
  logic [31:0] i_pwdata, i_instr_addr, i_opnd_addr, o_prdata, o_fetch_addr, rd;
  int n_fail, compares, cyc;
  assign {i_is_trap_op, i_is_ovfl_check, i_uses_pipe, i_is_pipelined_fp, i_is_pipe_fp_load,
    i_is_fp_op, i_is_fp_to_gp, i_is_lock, i_is_unlock, i_is_mem, i_page_accessed,
    i_xlate_fail, i_misaligned, i_fetch_fault, i_dual_mode, i_next_dual} = cls;
  // --------------
  // Block, pin sources, clock, watchdog
  // --------------
  tel_trap_entry DUT (.i_ref_clk, .i_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_retire, .i_instr_addr, .i_dual_mode,
    .i_next_dual, .i_is_trap_op, .i_is_ovfl_check, .i_uses_pipe, .i_is_pipelined_fp,
    .i_is_pipe_fp_load, .i_is_fp_op, .i_is_fp_to_gp, .i_is_lock, .i_is_unlock, .i_is_mem,
    .i_page_accessed, .i_opnd_addr, .i_xlate_fail, .i_misaligned, .i_fetch_fault,
    .i_int_ovfl, .i_bus_read, .i_parity_bad, .i_ext_irq_pin, .i_bus_fail_pin,
    .i_parity_check_pin, .o_trap, .o_fetch_addr, .o_handler_single, .o_abort,
    .o_restartable, .o_fp_half_commit, .o_bus_lock);
  tel_pin_source u_pins (.i_ref_clk, .i_fire_bus_fail_pin(fire_bus_fail_pin), .o_ext_irq_pin(i_ext_irq_pin),
    .o_bus_fail_pin(i_bus_fail_pin), .o_parity_check_pin(i_parity_check_pin));
  always #10 i_ref_clk = ~i_ref_clk;
  // Cuts a hang short
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  // --------------
  // Helpers
  // --------------
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'h1;
    do
      @(posedge i_ref_clk);
    while (o_pready !== 1'h1 && ++n < 20);
    rd = o_prdata;
    perr = o_pslverr;
    n_fail += (n == 20);
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h00000000);
    chk(rd & m, e);
  endtask
  task automatic clr;
    apb(1'h1, PS, 32'h000001F0);
    apb(1'h1, EX, 32'h0000003A);
  endtask
  // One retiring instruction, then one idle cycle
  task automatic ret(input logic [15:0] c, input logic [31:0] a);
    @(posedge i_ref_clk);
    i_retire <= 1'h1;
    cls <= c;
    i_instr_addr <= a;
    i_opnd_addr <= a;
    @(posedge i_ref_clk);
    i_retire <= 1'h0;
    cls <= 16'h0000;
    #1;
  endtask
  task automatic lseq(input int n);
    ret(16'h0100, 32'h00000000);
    ret(16'h0060, 32'h00000000);
    ret(16'h0080, 32'h00000000);
    repeat (n) ret(16'h0000, 32'h00000000);
    ret(16'h0040, 32'h00000000);
  endtask
  // --------------
  // Scenarios
  // --------------
  task automatic t_reset;
    chk(o_fetch_addr, tel_pkg::TEL_TRAP_VECTOR);
    rchk(PS, 32'hFFFFFFFF, {21'h000000, tel_pkg::TEL_PS_RESET});
    rchk(8'h18, 32'hFFFFFFFF, 32'h00000000);
    chk({31'h00000000, perr}, 32'h00000001);
  endtask
  task automatic t_trap;
    apb(1'h1, PS, 32'h00000005);
    ret(16'h8002, 32'h00000100);
    chk({o_trap, o_abort, o_handler_single, o_fp_half_commit, o_restartable}, 32'h1D);
    rchk(PS, 32'hFFFFFFFF, 32'h0000061A);
    rchk(tel_pkg::TEL_OFF_FAULT_ADDR, 32'hFFFFFFFF, 32'h00000100);
  endtask
  task automatic t_ovfl;
    clr;
    i_int_ovfl <= 1'h1;
    ret(16'h4002, 32'h00000200);
    chk({o_trap, o_fp_half_commit}, 32'h3);
    rchk(PS, 32'hFFFFFFFF, 32'h00000610);
    i_int_ovfl <= 1'h0;
    apb(1'h1, EX, 32'h00000000);
    ret(16'h4000, 32'h00000200);
    chk(o_trap, 32'h0);
  endtask
  task automatic t_pipe;
    clr;
    apb(1'h1, tel_pkg::TEL_OFF_FP_STATUS, 32'h00000040);
    ret(16'h2000, 32'h00000300);
    rchk(EX, 32'h8, 32'h8);
    rchk(PS, 32'h10, 32'h10);
    apb(1'h1, tel_pkg::TEL_OFF_FP_STATUS, 32'h00000000);
    clr;
    ret(16'h1000, 32'h00000300);
    rchk(EX, 32'h8, 32'h8);
  endtask
  task automatic t_opnd;
    clr;
    apb(1'h1, tel_pkg::TEL_OFF_DEBUG_ADDR, 32'h00000300);
    ret(16'h8040, 32'h00000300);
    rchk(PS, 32'h90, 32'h90);
    ret(16'h0048, 32'h00000405);
    chk(o_trap, 32'h1);
  endtask
  task automatic t_lock;
    ret(16'h0100, 32'h00000000);
    ret(16'h0040, 32'h00000000);
    chk(o_bus_lock, 32'h0);
    @(posedge i_ref_clk) #1;
    chk(o_bus_lock, 32'h1);
    ret(16'h0080, 32'h00000000);
    chk(o_bus_lock, 32'h1);
    ret(16'h0040, 32'h00000000);
    chk(o_bus_lock, 32'h0);
  endtask
  task automatic t_bus;
    clr;
    @(posedge i_ref_clk);
    fire_bus_fail_pin <= 1'h1;
    for (int n = 0; n < 12 && o_trap !== 1'h1; n++)
      @(posedge i_ref_clk) #1;
    chk({o_trap, o_restartable}, 32'h2);
    fire_bus_fail_pin <= 1'h0;
    rchk(EX, 32'h10, 32'h10);
  endtask
  task automatic t_tmo;
    clr;
    lseq(27);
    rchk(EX, 32'h2, 32'h0);
    lseq(28);
    rchk(EX, 32'h2, 32'h2);
  endtask
  initial
  begin
    {i_ref_clk, i_rst, i_ce, i_psel, i_penable, i_pwrite, i_retire, i_int_ovfl} = 8'h60;
    {i_bus_read, i_parity_bad, fire_bus_fail_pin, i_paddr, cls} = 27'h0000000;
    {i_pwdata, i_instr_addr, i_opnd_addr} = 96'h0;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    t_reset;
    t_trap;
    t_ovfl;
    t_pipe;
    t_opnd;
    t_lock;
    t_bus;
    t_tmo;
    end_of_test;
  end
endmodule
